// file: logic/reset_timeout_sequencer.v
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/10ps
`include "rst_seq_map.vh"

module reset_timeout_sequencer #(
    parameter ADDR_W = 4,
    parameter RC_PERIOD_NS = `RC_PERIOD_NS,
    parameter DELAY_TICKS = (`DELAY_TIME_US * 1000) / RC_PERIOD_NS,
    parameter DELAY_W = 16,
    parameter STARTUP_W = 11,
    parameter FILT_W = 8
) (
    input wire CLOCK,
    input wire RST_N,
    input wire [ADDR_W-1:0] AWADDR,
    input wire AWVALID,
    output wire AWREADY,
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    input wire WVALID,
    output wire WREADY,
    output reg [1:0] BRESP,
    output reg BVALID,
    input wire BREADY,
    input wire [ADDR_W-1:0] ARADDR,
    input wire ARVALID,
    output wire ARREADY,
    output reg [31:0] RDATA,
    output reg [1:0] RRESP,
    output reg RVALID,
    input wire RREADY,
    input wire SUPPLY_RISE,
    input wire EXT_RESET_N,
    input wire OSC_IN,
    input wire RC_OSC_IN,
    input wire WDOG_EXPIRE,
    input wire SLEEP_ACTIVE,
    output reg CORE_RESET,
    output reg LOAD_DEFAULTS,
    output reg WAKE_RESUME,
    output reg CLKOUT,
    output reg CLKOUT_OE,
    output reg EXPIRED_FLAG,
    output reg SLEEP_FLAG
);

localparam ST_RUN = 2'h0;
localparam ST_SUPPLY = 2'h1;
localparam ST_DELAY = 2'h2;
localparam ST_STARTUP = 2'h3;

// Full-width end counts, cut to the counter widths on purpose
localparam [31:0] DELAY_END = DELAY_TICKS - 1;
localparam [31:0] STARTUP_END = `STARTUP_CYCLES - 1;
localparam [31:0] FILT_END = ((`EXT_FILTER_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS) - 1;
localparam [DELAY_W-1:0] DELAY_LAST = DELAY_END[DELAY_W-1:0];
localparam [STARTUP_W-1:0] STARTUP_LAST = STARTUP_END[STARTUP_W-1:0];
localparam [FILT_W-1:0] FILT_LAST = FILT_END[FILT_W-1:0];

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detection

reg [3:0] sync_a;
reg [3:0] sync_b;
reg supply_last;
reg osc_last;
reg rc_last;
wire supply;
wire ext_n;
wire osc;
wire rc;
wire supply_start;
wire osc_rise;
wire rc_rise;

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        sync_a <= 4'h2;
        sync_b <= 4'h2;
        supply_last <= 1'b0;
        osc_last <= 1'b0;
        rc_last <= 1'b0;
    end else begin
        sync_a <= {RC_OSC_IN, OSC_IN, EXT_RESET_N, SUPPLY_RISE};
        sync_b <= sync_a;
        supply_last <= supply;
        osc_last <= osc;
        rc_last <= rc;
    end
end

assign supply = sync_b[0];
assign ext_n = sync_b[1];
assign osc = sync_b[2];
assign rc = sync_b[3];
// Only the rising supply pulse marks a supply event; the sequencer leaves ST_SUPPLY when the pulse falls
assign supply_start = supply & ~supply_last;
assign osc_rise = osc & ~osc_last;
assign rc_rise = rc & ~rc_last;

////////////////////////////////////////////////////////////////////////////////
// External reset noise filter

reg [FILT_W-1:0] filt_cnt;
reg ext_hold;
reg ext_start;

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        filt_cnt <= {FILT_W{1'b0}};
        ext_hold <= 1'b0;
        ext_start <= 1'b0;
    end else begin
        ext_start <= 1'b0;
        if (ext_n) begin
            filt_cnt <= {FILT_W{1'b0}};
            ext_hold <= 1'b0;
        end else if (!ext_hold) begin
            if (filt_cnt == FILT_LAST) begin
                ext_hold <= 1'b1;
                ext_start <= 1'b1;
            end else begin
                filt_cnt <= filt_cnt + 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration and reset kind

reg [31:0] config_word;
wire [1:0] osc_mode;
wire delay_off;
wire crystal;
reg [2:0] event_kind;

assign osc_mode = config_word[`CFG_MODE_MSB:`CFG_MODE_LSB];
assign delay_off = config_word[`CFG_DELAY_OFF_BIT];
assign crystal = (osc_mode != `MODE_RC);

always @* begin
    if (supply_start) begin
        event_kind = `KIND_SUPPLY;
    end else if (ext_start) begin
        event_kind = SLEEP_ACTIVE ? `KIND_EXT_SLEEP : `KIND_EXT_RUN;
    end else if (WDOG_EXPIRE && !CORE_RESET) begin
        event_kind = SLEEP_ACTIVE ? `KIND_WDOG_WAKE : `KIND_WDOG_RUN;
    end else begin
        event_kind = `KIND_NONE;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Time-out sequencer

reg [1:0] state;
reg [1:0] next_state;
reg [DELAY_W-1:0] delay_cnt;
reg [STARTUP_W-1:0] startup_cnt;
wire next_core_reset;

always @* begin
    next_state = state;
    case (state)
        ST_SUPPLY: begin
            if (!supply) begin
                if (!delay_off) begin
                    next_state = ST_DELAY;
                end else if (crystal) begin
                    next_state = ST_STARTUP;
                end else begin
                    next_state = ST_RUN;
                end
            end
        end
        ST_DELAY: begin
            if (rc_rise && delay_cnt == DELAY_LAST) begin
                next_state = crystal ? ST_STARTUP : ST_RUN;
            end
        end
        ST_STARTUP: begin
            if (osc_rise && startup_cnt == STARTUP_LAST) begin
                next_state = ST_RUN;
            end
        end
        default: begin
            if (event_kind == `KIND_WDOG_WAKE && crystal) begin
                next_state = ST_STARTUP;
            end
        end
    endcase
    // Supply rise restarts the whole sequence from any state
    if (supply) begin
        next_state = ST_SUPPLY;
    end
end

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        state <= ST_SUPPLY;
        delay_cnt <= {DELAY_W{1'b0}};
        startup_cnt <= {STARTUP_W{1'b0}};
    end else begin
        state <= next_state;
        if (state != ST_DELAY) begin
            delay_cnt <= {DELAY_W{1'b0}};
        end else if (rc_rise) begin
            delay_cnt <= delay_cnt + 1'b1;
        end
        if (state != ST_STARTUP) begin
            startup_cnt <= {STARTUP_W{1'b0}};
        end else if (osc_rise) begin
            startup_cnt <= startup_cnt + 1'b1;
        end
    end
end

// Delays ignore the pin, so they may end while the pin is still low
assign next_core_reset = supply | ext_hold | (next_state != ST_RUN);

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        CORE_RESET <= 1'b1;
        LOAD_DEFAULTS <= 1'b0;
        WAKE_RESUME <= 1'b0;
    end else begin
        CORE_RESET <= next_core_reset;
        LOAD_DEFAULTS <= (event_kind != `KIND_NONE) && (event_kind != `KIND_WDOG_WAKE);
        WAKE_RESUME <= (event_kind == `KIND_WDOG_WAKE);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Clock output divider

reg [1:0] div_cnt;

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        div_cnt <= 2'h0;
        CLKOUT <= 1'b0;
        CLKOUT_OE <= 1'b0;
    end else begin
        if (osc_rise) begin
            div_cnt <= div_cnt + 1'b1;
        end
        CLKOUT <= div_cnt[1];
        CLKOUT_OE <= ~crystal;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus write channel

reg aw_held;
reg [ADDR_W-1:0] aw_addr;
reg w_held;
reg [31:0] w_data;
reg [3:0] w_strb;
wire wr_go;
wire wr_config;
wire wr_cause;
wire wr_keep;
wire wr_loaded;
wire wr_mapped;

assign AWREADY = ~aw_held & ~BVALID;
assign WREADY = ~w_held & ~BVALID;
assign wr_go = aw_held & w_held & ~BVALID;
assign wr_config = wr_go && (aw_addr == `ADDR_CONFIG);
assign wr_cause = wr_go && (aw_addr == `ADDR_CAUSE);
assign wr_keep = wr_go && (aw_addr == `ADDR_KEEP);
assign wr_loaded = wr_go && (aw_addr == `ADDR_LOADED);
assign wr_mapped = wr_config | wr_cause | wr_keep | wr_loaded;

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        aw_held <= 1'b0;
        aw_addr <= {ADDR_W{1'b0}};
        w_held <= 1'b0;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        BVALID <= 1'b0;
        BRESP <= `RESP_OKAY;
    end else begin
        if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR;
        end
        if (WVALID && WREADY) begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
        end
        if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registers

reg supply_flag;
reg [2:0] last_kind;
reg [31:0] keep_word;
reg [31:0] loaded_word;
integer i;
integer j;

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        config_word <= `CFG_RESET;
    end else if (wr_config && w_strb[0]) begin
        config_word[`CFG_DELAY_OFF_BIT:`CFG_MODE_LSB] <= w_data[`CFG_DELAY_OFF_BIT:`CFG_MODE_LSB];
    end
end

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        EXPIRED_FLAG <= 1'b1;
        SLEEP_FLAG <= 1'b1;
        supply_flag <= 1'b0;
        last_kind <= `KIND_SUPPLY;
    end else begin
        if (event_kind != `KIND_NONE) begin
            last_kind <= event_kind;
        end
        case (event_kind)
            `KIND_SUPPLY: begin
                EXPIRED_FLAG <= 1'b1;
                SLEEP_FLAG <= 1'b1;
            end
            `KIND_EXT_RUN: begin
                EXPIRED_FLAG <= 1'b1;
                SLEEP_FLAG <= 1'b1;
            end
            `KIND_EXT_SLEEP: begin
                EXPIRED_FLAG <= 1'b1;
                SLEEP_FLAG <= 1'b0;
            end
            `KIND_WDOG_RUN: begin
                EXPIRED_FLAG <= 1'b0;
                SLEEP_FLAG <= 1'b1;
            end
            `KIND_WDOG_WAKE: begin
                EXPIRED_FLAG <= 1'b0;
                SLEEP_FLAG <= 1'b0;
            end
            default: begin
            end
        endcase
        // Hardware clear wins over a software set in the same cycle
        if (event_kind == `KIND_SUPPLY) begin
            supply_flag <= 1'b0;
        end else if (wr_cause && w_strb[0] && w_data[`CAUSE_SUPPLY_BIT]) begin
            supply_flag <= 1'b1;
        end
    end
end

// No reset at all: contents survive every reset kind
always @(posedge CLOCK) begin
    for (i = 0; i < 4; i = i + 1) begin
        if (wr_keep && w_strb[i]) begin
            keep_word[i*8 +: 8] <= w_data[i*8 +: 8];
        end
    end
end

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        loaded_word <= `LOADED_RESET;
    end else if ((event_kind != `KIND_NONE) && (event_kind != `KIND_WDOG_WAKE)) begin
        loaded_word <= `LOADED_RESET;
    end else begin
        for (j = 0; j < 4; j = j + 1) begin
            if (wr_loaded && w_strb[j]) begin
                loaded_word[j*8 +: 8] <= w_data[j*8 +: 8];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus read channel

reg [31:0] cause_word;
reg [31:0] read_word;
reg read_ok;

always @* begin
    cause_word = 32'h00000000;
    cause_word[`CAUSE_EXPIRED_BIT] = EXPIRED_FLAG;
    cause_word[`CAUSE_SLEEP_BIT] = SLEEP_FLAG;
    cause_word[`CAUSE_SUPPLY_BIT] = supply_flag;
    cause_word[`CAUSE_KIND_MSB:`CAUSE_KIND_LSB] = last_kind;
    cause_word[`CAUSE_CORE_RST_BIT] = CORE_RESET;
    cause_word[`CAUSE_DELAY_BIT] = (state == ST_DELAY);
    cause_word[`CAUSE_STARTUP_BIT] = (state == ST_STARTUP);
end

always @* begin
    read_ok = 1'b1;
    if (ARADDR == `ADDR_CONFIG) begin
        read_word = config_word;
    end else if (ARADDR == `ADDR_CAUSE) begin
        read_word = cause_word;
    end else if (ARADDR == `ADDR_KEEP) begin
        read_word = keep_word;
    end else if (ARADDR == `ADDR_LOADED) begin
        read_word = loaded_word;
    end else begin
        read_word = 32'h00000000;
        read_ok = 1'b0;
    end
end

assign ARREADY = ~RVALID;

always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
        RVALID <= 1'b0;
        RDATA <= 32'h00000000;
        RRESP <= `RESP_OKAY;
    end else begin
        if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA <= read_word;
            RRESP <= read_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end
end

endmodule

// file: logic/rst_seq_map.vh
`ifndef RST_SEQ_MAP_VH
`define RST_SEQ_MAP_VH

// Register byte offsets
`define ADDR_CONFIG 4'h0
`define ADDR_CAUSE 4'h4
`define ADDR_KEEP 4'h8
`define ADDR_LOADED 4'hC

// Configuration register fields
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 1
`define CFG_DELAY_OFF_BIT 2
`define CFG_RESET 32'h00000001

// Oscillator modes
`define MODE_LOW_POWER 2'h0
`define MODE_CRYSTAL 2'h1
`define MODE_HIGH_SPEED 2'h2
`define MODE_RC 2'h3

// Reset-cause register fields
`define CAUSE_EXPIRED_BIT 0
`define CAUSE_SLEEP_BIT 1
`define CAUSE_SUPPLY_BIT 2
`define CAUSE_KIND_LSB 3
`define CAUSE_KIND_MSB 5
`define CAUSE_CORE_RST_BIT 6
`define CAUSE_DELAY_BIT 7
`define CAUSE_STARTUP_BIT 8

// Reset kinds
`define KIND_NONE 3'h0
`define KIND_SUPPLY 3'h1
`define KIND_EXT_RUN 3'h2
`define KIND_EXT_SLEEP 3'h3
`define KIND_WDOG_RUN 3'h4
`define KIND_WDOG_WAKE 3'h5

// Reset value of the loaded register
`define LOADED_RESET 32'h000000FF

// Timing
`define CLOCK_PERIOD_NS 25
`define DELAY_TIME_US 72000
`define RC_PERIOD_NS 18000
`define STARTUP_CYCLES 1024
`define EXT_FILTER_NS 2000

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: test/rts_far_side.sv
`timescale 1ns/10ps
module rts_far_side (
    input wire logic pin_low,
    output logic osc_in,
    output logic rc_osc_in,
    output logic ext_reset_n
);
    ////////////////////////////////////////
    // Main oscillator at a quarter of the bus clock
    initial begin
        osc_in = 1'b0;
        forever #50 osc_in = ~osc_in;
    end
    initial begin
        rc_osc_in = 1'b0;
        forever #100 rc_osc_in = ~rc_osc_in;
    end
    ////////////////////////////////////////
    // Pin driver; a late release starts the core at once
    assign ext_reset_n = ~pin_low;
endmodule

// file: test/rts_chk.sv
`timescale 1ns/10ps
module rts_chk (
    input wire CLOCK,
    input wire RST_N,
    input wire SUPPLY_RISE,
    input wire EXT_RESET_N,
    input wire WDOG_EXPIRE,
    input wire CORE_RESET,
    input wire LOAD_DEFAULTS,
    input wire WAKE_RESUME,
    input wire CLKOUT,
    input wire EXPIRED_FLAG,
    input wire SLEEP_FLAG,
    input wire BVALID,
    input wire BREADY,
    input wire RVALID,
    input wire RREADY
);
    logic [7:0] low_run;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            low_run <= 8'h00;
        end else if (EXT_RESET_N) begin
            low_run <= 8'h00;
        end else if (low_run != 8'hFF) begin
            low_run <= low_run + 8'h01;
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    sequence wake_ev;
        WAKE_RESUME;
    endsequence
    sequence no_load;
        !LOAD_DEFAULTS [*4];
    endsequence
    supply_hold_a: assert property (SUPPLY_RISE [*5] |-> CORE_RESET)
        else $error("core ran during supply pulse");
    pin_hold_a: assert property (low_run >= 8'h56 |-> CORE_RESET)
        else $error("core ran with pin held low");
    wake_noload_a: assert property (wake_ev |-> no_load)
        else $error("defaults loaded on wake");
    load_pulse_a: assert property (LOAD_DEFAULTS |=> !LOAD_DEFAULTS)
        else $error("load pulse too long");
    wake_flags_a: assert property (wake_ev |-> ##[0:1] (!EXPIRED_FLAG && !SLEEP_FLAG))
        else $error("wake flags wrong");
    wdog_ignore_a: assert property (CORE_RESET && WDOG_EXPIRE && !SUPPLY_RISE |=> !WAKE_RESUME && !LOAD_DEFAULTS)
        else $error("watchdog taken in reset");
    clkout_rate_a: assert property ($changed(CLKOUT) |=> $stable(CLKOUT) [*4])
        else $error("clock output too fast");
    b_done_a: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write response stuck");
    r_done_a: assert property (RVALID && RREADY |=> !RVALID)
        else $error("read data stuck");
endmodule

// file: test/test_reset_timeout_sequencer.sv
`timescale 1ns/10ps
module test_reset_timeout_sequencer;
    localparam int PW = 8;
    localparam int OT = 4096;
    logic CLOCK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [4:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, d, m_loaded, m_keep;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP, r;
    logic SUPPLY_RISE, EXT_RESET_N, OSC_IN, RC_OSC_IN, WDOG_EXPIRE, SLEEP_ACTIVE, pin_low, prev;
    logic CORE_RESET, LOAD_DEFAULTS, WAKE_RESUME, CLKOUT, CLKOUT_OE, EXPIRED_FLAG, SLEEP_FLAG;
    int fail_count = 0;
    int num_checks = 0;
    int n, k, seed, m_exp, m_slp, m_sup, m_kind;
    int loads = 0;
    int wakes = 0;
    reset_timeout_sequencer #(.ADDR_W(5), .DELAY_TICKS(PW)) DUT (.*);
    rts_far_side far (.pin_low(pin_low), .osc_in(OSC_IN), .rc_osc_in(RC_OSC_IN), .ext_reset_n(EXT_RESET_N));
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    // Counts load and resume pulses for the closing check
    always @(posedge CLOCK) begin
        if (LOAD_DEFAULTS === 1'b1) loads++;
        if (WAKE_RESUME === 1'b1) wakes++;
    end
    ////////////////////////////////////////
    task chk(input bit ok, input string m);
        num_checks++;
        if (!ok) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] v);
        k = 0;
        AWADDR <= a;
        WDATA <= v;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLOCK);
            k++;
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (!BVALID && k < 60);
        r = BRESP;
        BREADY <= 1'b0;
        @(posedge CLOCK);
        chk(k < 60, "write hang");
    endtask
    task rd(input logic [4:0] a);
        k = 0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CLOCK);
            k++;
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (!RVALID && k < 60);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
        @(posedge CLOCK);
        chk(k < 60, "read hang");
    endtask
    task wait_run;
        n = 0;
        while (CORE_RESET !== 1'b0 && n < 9000) begin
            @(posedge CLOCK);
            n++;
        end
    endtask
    task pin_pulse(input int len);
        pin_low <= 1'b1;
        repeat (len) @(posedge CLOCK);
        pin_low <= 1'b0;
        @(posedge CLOCK);
        wait_run;
    endtask
    task supply(input int hold);
        SUPPLY_RISE <= 1'b1;
        repeat (10) @(posedge CLOCK);
        SUPPLY_RISE <= 1'b0;
        repeat (hold) @(posedge CLOCK);
        pin_low <= 1'b0;
        @(posedge CLOCK);
        wait_run;
    endtask
    task pulse_wd;
        WDOG_EXPIRE <= 1'b1;
        @(posedge CLOCK);
        WDOG_EXPIRE <= 1'b0;
    endtask
    ////////////////////////////////////////
    // Reference model of the cause flags and loaded register
    task mdl(input int kind);
        if (kind != 5) m_loaded = 32'h000000FF;
        m_exp = kind < 4;
        m_slp = kind == 1 || kind == 2 || kind == 4;
        if (kind == 1) m_sup = 0;
        m_kind = kind;
    endtask
    task regs;
        rd(5'h04);
        chk(d === 32'(m_exp + 2 * m_slp + 4 * m_sup + 8 * m_kind), "cause");
        rd(5'h0C);
        chk(d === m_loaded, "loaded");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #1000000;
        fail_count++;
        final_report;
    end
    initial begin
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, SUPPLY_RISE, WDOG_EXPIRE, SLEEP_ACTIVE, pin_low} = '0;
        AWADDR = 5'h00;
        ARADDR = 5'h00;
        WDATA = 32'h0;
        WSTRB = 4'hF;
        RST_N = 1'b0;
        seed = 32'h3BA5;
        repeat (6) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        wait_run;
        chk(n > OT + PW * 8 - 20 && n < OT + PW * 8 + 20, "power-up time");
        mdl(1);
        rd(5'h00);
        chk(d === 32'h00000001, "config");
        chk(CLKOUT_OE === 1'b0, "clkout off in crystal");
        regs;
        rd(5'h10);
        chk(r === 2'h2 && d === 32'h0, "unmapped read");
        wr(5'h10, 32'h0);
        chk(r === 2'h2, "unmapped write");
        $display("test power-up done");
        m_keep = $random(seed);
        m_loaded = $random(seed);
        wr(5'h08, m_keep);
        wr(5'h0C, m_loaded);
        wr(5'h04, 32'h4);
        m_sup = 1;
        pin_pulse(20);
        chk(n == 0 && CORE_RESET === 1'b0, "glitch");
        regs;
        pin_pulse(100);
        chk(n < 10, "pin run");
        mdl(2);
        regs;
        rd(5'h08);
        chk(d === m_keep, "keep");
        SLEEP_ACTIVE <= 1'b1;
        pin_pulse(100);
        SLEEP_ACTIVE <= 1'b0;
        chk(n < 10, "pin sleep");
        mdl(3);
        regs;
        $display("test pin done");
        m_loaded = $random(seed);
        wr(5'h0C, m_loaded);
        pulse_wd;
        repeat (4) @(posedge CLOCK);
        wait_run;
        mdl(4);
        regs;
        m_loaded = $random(seed);
        wr(5'h0C, m_loaded);
        SLEEP_ACTIVE <= 1'b1;
        pulse_wd;
        repeat (20) @(posedge CLOCK);
        pulse_wd;
        wait_run;
        SLEEP_ACTIVE <= 1'b0;
        chk(n > OT - 60 && n < OT + 20, "wake count");
        mdl(5);
        regs;
        rd(5'h08);
        chk(d === m_keep, "keep");
        $display("test watchdog done");
        wr(5'h00, 32'h7);
        supply(0);
        chk(n < 10, "rc no delay");
        chk(CLKOUT_OE === 1'b1, "clkout enable");
        mdl(1);
        regs;
        k = 0;
        prev = CLKOUT;
        repeat (160) begin
            @(posedge CLOCK);
            if (CLKOUT !== prev) k++;
            prev = CLKOUT;
        end
        chk(k >= 19 && k <= 21, "clkout rate");
        wr(5'h00, 32'h3);
        supply(0);
        chk(n > PW * 8 - 20 && n < PW * 8 + 20, "rc delay");
        pin_low <= 1'b1;
        repeat (100) @(posedge CLOCK);
        supply(150);
        chk(n < 10, "late pin release");
        chk(loads == 7 && wakes == 1, "load and resume pulses");
        $display("test supply done");
        final_report;
    end
endmodule
bind reset_timeout_sequencer rts_chk chk_inst (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .SUPPLY_RISE(SUPPLY_RISE),
    .EXT_RESET_N(EXT_RESET_N),
    .WDOG_EXPIRE(WDOG_EXPIRE),
    .CORE_RESET(CORE_RESET),
    .LOAD_DEFAULTS(LOAD_DEFAULTS),
    .WAKE_RESUME(WAKE_RESUME),
    .CLKOUT(CLKOUT),
    .EXPIRED_FLAG(EXPIRED_FLAG),
    .SLEEP_FLAG(SLEEP_FLAG),
    .BVALID(BVALID),
    .BREADY(BREADY),
    .RVALID(RVALID),
    .RREADY(RREADY)
);
